// ===== design/slasc_pkg.sv
// shared constants and types for the lane align and sync control block
package slasc_pkg;
	localparam int LANES = 4;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [4:0] REG_LOCK_MODE = 5'h02;
	localparam logic [4:0] REG_MAN_LOCK_10 = 5'h03;
	localparam logic [4:0] REG_MAN_LOCK_32 = 5'h04;
	localparam logic [4:0] REG_CLK_ALIGN = 5'h05;
	localparam logic [4:0] REG_DESCRAMBLE = 5'h06;
	localparam logic [4:0] REG_ILA_CTRL = 5'h07;
	localparam logic [4:0] REG_ALIGN_MODE = 5'h08;
	localparam logic [4:0] REG_MAN_ALIGN_01 = 5'h09;
	localparam logic [4:0] REG_MAN_ALIGN_23 = 5'h0A;
	localparam logic [4:0] REG_ERR_SELECT = 5'h0B;
	localparam logic [4:0] REG_SYNC_MODE = 5'h0C;
	localparam logic [4:0] REG_POLARITY = 5'h0D;
	localparam int REG_FIRST = 2;
	localparam int REG_LAST = 13;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DEFAULT = 8'h00;
	localparam logic [7:0] RST_ILA_CTRL = 8'h83;
	localparam logic [7:0] RST_RDATA = 8'h00;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int LOCK_SR_BIT = 0;
	localparam int LOCK_SEL_LSB = 4;
	localparam int SWAP_LSB = 4;
	localparam int EDGE_LSB = 0;
	localparam int SCR_MAN_LSB = 4;
	localparam int SCR_FORCE_LSB = 0;
	localparam int ILA_MODE_BIT = 7;
	localparam int ILA_TRIG_LSB = 5;
	localparam int ILA_START_LSB = 2;
	localparam int ILA_EN_BIT = 1;
	localparam int SCR_EN_BIT = 0;
	localparam int ALIGN_DYN_BIT = 1;
	localparam int ALIGN_FORCE_BIT = 0;
	localparam int ERR_CTRL_UP_LSB = 6;
	localparam int ERR_CTRL_LO_LSB = 4;
	localparam int ERR_CODE_UP_LSB = 2;
	localparam int ERR_CODE_LO_LSB = 0;
	localparam int SYNC_REINIT_LSB = 5;
	localparam int SYNC_POLARITY_BIT = 4;
	localparam int SYNC_SEL_LSB = 0;
	localparam int NIB = 4;
	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [3:0] SYNC_FIXED_ONE = 4'hA;
	localparam logic [2:0] REINIT_NEVER = 3'h7;
	localparam logic [2:0] A_COUNT_MAX = 3'h4;
	localparam logic [3:0] MASK_ALL = 4'hF;
	localparam logic [3:0] MASK_LOW = 4'h3;
	localparam logic [3:0] MASK_HIGH = 4'hC;

	typedef enum logic [2:0] {
		ILA_WAIT = 3'b001,
		ILA_COUNT = 3'b010,
		ILA_DONE = 3'b100
	} slasc_ila_t;

	typedef struct packed {
		logic divided_clock;
		logic [7:0] align_input;
		logic [3:0] auto_lock_pos;
		logic locked;
		logic a_symbol;
		logic [3:0] auto_delay;
		logic misaligned;
		logic unexpected_ctrl;
		logic code_error;
		logic lane_reset;
		logic lane_sync;
	} slasc_lane_in_t;

	typedef struct packed {
		logic [7:0] data;
		logic data_valid;
		logic [3:0] word_pos;
		logic descramble_on;
		logic [3:0] align_delay;
	} slasc_lane_out_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} slasc_reg_req_t;

	typedef struct packed {
		logic [REG_LAST:REG_FIRST][7:0] regs;
		logic [3:0] prev_div;
		slasc_lane_out_t [3:0] lane_out;
		logic [3:0][2:0] a_cnt;
		slasc_ila_t [1:0] ila_st;
		logic [1:0] ila_aligned;
		logic [1:0] ila_strobe;
		logic [1:0] ctrl_err_trig;
		logic [1:0] code_err_trig;
		logic reinit_request;
		logic sync_out;
		logic [7:0] rdata;
	} slasc_state_t;
endpackage

// ===== design/slasc_top.sv
// lane front end: alignment, sync combining and their control registers
`timescale 1ns/1ps
`default_nettype none
module slasc_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire slasc_pkg::slasc_reg_req_t reg_req,
	input wire slasc_pkg::slasc_lane_in_t [3:0] lane_in,
	output logic [7:0] reg_rdata,
	output slasc_pkg::slasc_lane_out_t [3:0] lane_out,
	output logic [1:0] ila_aligned,
	output logic [1:0] ila_strobe,
	output logic [1:0] ctrl_err_trig,
	output logic [1:0] code_err_trig,
	output logic reinit_request,
	output logic sync_out
);
	slasc_pkg::slasc_state_t q;
	slasc_pkg::slasc_state_t next_q;

	function automatic logic [7:0] slasc_reverse(input logic [7:0] b);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	function automatic logic slasc_pair_sel(input logic [1:0] code,
		input logic lo, input logic hi);
		logic r;
		r = 1'b0;
		case (code)
			2'b00: r = lo | hi;
			2'b01: r = lo & hi;
			2'b10: r = lo;
			default: r = hi;
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// configuration fields
	// ------------------------------------------------------------
	logic [7:0] c_lock, c_ca, c_scr, c_ila, c_align, c_err, c_sync, c_pol;
	assign c_lock = q.regs[slasc_pkg::REG_LOCK_MODE];
	assign c_ca = q.regs[slasc_pkg::REG_CLK_ALIGN];
	assign c_scr = q.regs[slasc_pkg::REG_DESCRAMBLE];
	assign c_ila = q.regs[slasc_pkg::REG_ILA_CTRL];
	assign c_align = q.regs[slasc_pkg::REG_ALIGN_MODE];
	assign c_err = q.regs[slasc_pkg::REG_ERR_SELECT];
	assign c_sync = q.regs[slasc_pkg::REG_SYNC_MODE];
	assign c_pol = q.regs[slasc_pkg::REG_POLARITY];

	logic [3:0] locked, rst_v, sync_v, unexp_v, nit_v, edge_v;
	logic sr_write;
	always_comb begin
		for (int l = 0; l < slasc_pkg::LANES; l++) begin
			locked[l] = lane_in[l].locked;
			rst_v[l] = lane_in[l].lane_reset;
			sync_v[l] = lane_in[l].lane_sync;
			unexp_v[l] = lane_in[l].unexpected_ctrl;
			nit_v[l] = lane_in[l].code_error;
			edge_v[l] = c_ca[slasc_pkg::EDGE_LSB + l] ?
				(lane_in[l].divided_clock & ~q.prev_div[l]) :
				(~lane_in[l].divided_clock & q.prev_div[l]);
		end
	end
	// soft reset on write of one
	assign sr_write = reg_req.wr && reg_req.addr == slasc_pkg::REG_LOCK_MODE &&
		reg_req.wdata[slasc_pkg::LOCK_SR_BIT];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] byte_v;
		logic [3:0] mask;
		logic [2:0] need;
		logic [2:0] start;
		logic start_ok;
		logic reached;
		logic sync_term;
		logic [3:0] lidx;
		byte_v = '0;
		mask = '0;
		need = '0;
		start = '0;
		start_ok = 1'b0;
		reached = 1'b0;
		sync_term = 1'b0;
		lidx = '0;
		next_q = q;
		next_q.ila_strobe = '0;
		// register port
		if (reg_req.wr && reg_req.addr >= 5'(slasc_pkg::REG_FIRST) &&
			reg_req.addr <= 5'(slasc_pkg::REG_LAST)) begin
			next_q.regs[reg_req.addr] = reg_req.wdata;
		end
		if (reg_req.rd) begin
			if (reg_req.addr >= 5'(slasc_pkg::REG_FIRST) &&
				reg_req.addr <= 5'(slasc_pkg::REG_LAST)) begin
				next_q.rdata = q.regs[reg_req.addr];
			end else begin
				next_q.rdata = slasc_pkg::RST_RDATA;
			end
		end
		// per-lane datapath
		for (int l = 0; l < slasc_pkg::LANES; l++) begin
			next_q.prev_div[l] = lane_in[l].divided_clock;
			next_q.lane_out[l].data_valid = edge_v[l];
			if (edge_v[l]) begin
				byte_v = c_ca[slasc_pkg::SWAP_LSB + l] ?
					slasc_reverse(lane_in[l].align_input) :
					lane_in[l].align_input;
				next_q.lane_out[l].data = c_pol[l] ? ~byte_v : byte_v;
			end
			next_q.lane_out[l].word_pos = c_lock[slasc_pkg::LOCK_SEL_LSB + l] ?
				q.regs[slasc_pkg::REG_MAN_LOCK_10 + (l >> 1)][(l % 2) * 4 +: 4] :
				lane_in[l].auto_lock_pos;
			next_q.lane_out[l].descramble_on =
				c_scr[slasc_pkg::SCR_FORCE_LSB + l] ?
				c_scr[slasc_pkg::SCR_MAN_LSB + l] :
				(lane_in[l].locked & c_ila[slasc_pkg::SCR_EN_BIT]);
			next_q.lane_out[l].align_delay = c_align[slasc_pkg::ALIGN_FORCE_BIT] ?
				q.regs[slasc_pkg::REG_MAN_ALIGN_01 + (l >> 1)][(l % 2) * 4 +: 4] :
				lane_in[l].auto_delay;
		end
		// inter-lane alignment, one machine per pair
		need = {1'b0, c_ila[slasc_pkg::ILA_TRIG_LSB +: 2]} + 3'h1;
		start = c_ila[slasc_pkg::ILA_START_LSB +: 3];
		for (int p = 0; p < 2; p++) begin
			mask = c_ila[slasc_pkg::ILA_MODE_BIT] ? slasc_pkg::MASK_ALL :
				(p == 0 ? slasc_pkg::MASK_LOW : slasc_pkg::MASK_HIGH);
			case (start)
				3'b000: start_ok = &(locked | ~mask);
				3'b001: start_ok = |(locked & mask);
				3'b010, 3'b011, 3'b100, 3'b101: begin
					lidx = 4'(start) - 4'h2;
					start_ok = locked[lidx[1:0]];
				end
				default: start_ok = 1'b0;
			endcase
			reached = 1'b1;
			for (int l = 0; l < slasc_pkg::LANES; l++) begin
				if (mask[l] && q.a_cnt[l] < need) begin
					reached = 1'b0;
				end
			end
			case (q.ila_st[p])
				slasc_pkg::ILA_WAIT: begin
					if (c_ila[slasc_pkg::ILA_EN_BIT] && start_ok) begin
						next_q.ila_st[p] = slasc_pkg::ILA_COUNT;
					end
				end
				slasc_pkg::ILA_COUNT: begin
					if (!c_ila[slasc_pkg::ILA_EN_BIT]) begin
						next_q.ila_st[p] = slasc_pkg::ILA_WAIT;
					end else if (reached) begin
						next_q.ila_st[p] = slasc_pkg::ILA_DONE;
						next_q.ila_strobe[p] = 1'b1;
					end
				end
				slasc_pkg::ILA_DONE: begin
					if (!c_ila[slasc_pkg::ILA_EN_BIT] ||
						(c_align[slasc_pkg::ALIGN_DYN_BIT] &&
						|(mask & {lane_in[3].misaligned, lane_in[2].misaligned,
						lane_in[1].misaligned, lane_in[0].misaligned}))) begin
						next_q.ila_st[p] = slasc_pkg::ILA_WAIT;
					end
				end
				default: next_q.ila_st[p] = slasc_pkg::ILA_WAIT;
			endcase
		end
		for (int l = 0; l < slasc_pkg::LANES; l++) begin
			if (q.ila_st[l >> 1] != slasc_pkg::ILA_COUNT) begin
				next_q.a_cnt[l] = '0;
			end else if (lane_in[l].a_symbol &&
				q.a_cnt[l] < slasc_pkg::A_COUNT_MAX) begin
				next_q.a_cnt[l] = q.a_cnt[l] + 3'h1;
			end
		end
		if (sr_write) begin
			next_q.ila_st = '{slasc_pkg::ILA_WAIT, slasc_pkg::ILA_WAIT};
			next_q.a_cnt = '0;
			next_q.ila_strobe = '0;
		end
		for (int p = 0; p < 2; p++) begin
			next_q.ila_aligned[p] = next_q.ila_st[p] == slasc_pkg::ILA_DONE;
		end
		next_q.ctrl_err_trig[0] = slasc_pair_sel(
			c_err[slasc_pkg::ERR_CTRL_LO_LSB +: 2], unexp_v[0], unexp_v[1]);
		next_q.ctrl_err_trig[1] = slasc_pair_sel(
			c_err[slasc_pkg::ERR_CTRL_UP_LSB +: 2], unexp_v[2], unexp_v[3]);
		next_q.code_err_trig[0] = slasc_pair_sel(
			c_err[slasc_pkg::ERR_CODE_LO_LSB +: 2], nit_v[0], nit_v[1]);
		next_q.code_err_trig[1] = slasc_pair_sel(
			c_err[slasc_pkg::ERR_CODE_UP_LSB +: 2], nit_v[2], nit_v[3]);
		case (c_sync[slasc_pkg::SYNC_REINIT_LSB +: 3])
			3'h0: next_q.reinit_request = |rst_v;
			3'h1: next_q.reinit_request = rst_v[0] | rst_v[1];
			3'h2: next_q.reinit_request = rst_v[2] | rst_v[3];
			3'h3: next_q.reinit_request = rst_v[0];
			3'h4: next_q.reinit_request = rst_v[1];
			3'h5: next_q.reinit_request = rst_v[2];
			3'h6: next_q.reinit_request = rst_v[3];
			default: next_q.reinit_request = 1'b0;
		endcase
		case (c_sync[slasc_pkg::SYNC_SEL_LSB +: 4])
			4'h0: sync_term = |sync_v;
			4'h1: sync_term = &sync_v;
			4'h2: sync_term = sync_v[0] | sync_v[1];
			4'h3: sync_term = sync_v[0] & sync_v[1];
			4'h4: sync_term = sync_v[2] | sync_v[3];
			4'h5: sync_term = sync_v[2] & sync_v[3];
			4'h6: sync_term = sync_v[0];
			4'h7: sync_term = sync_v[1];
			4'h8: sync_term = sync_v[2];
			4'h9: sync_term = sync_v[3];
			4'hA: sync_term = 1'b1;
			default: sync_term = 1'b0;
		endcase
		next_q.sync_out = c_sync[slasc_pkg::SYNC_POLARITY_BIT] ? sync_term :
			~sync_term;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.regs[slasc_pkg::REG_ILA_CTRL] <= slasc_pkg::RST_ILA_CTRL;
			q.ila_st <= '{slasc_pkg::ILA_WAIT, slasc_pkg::ILA_WAIT};
			q.sync_out <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign reg_rdata = q.rdata;
	assign lane_out = q.lane_out;
	assign ila_aligned = q.ila_aligned;
	assign ila_strobe = q.ila_strobe;
	assign ctrl_err_trig = q.ctrl_err_trig;
	assign code_err_trig = q.code_err_trig;
	assign reinit_request = q.reinit_request;
	assign sync_out = q.sync_out;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_sync_fixed_one;
		(c_sync[3:0] == 4'hA && !c_sync[4]) |=> !sync_out;
	endproperty
	a_sync_fixed_one: assert property (p_sync_fixed_one)
		else $error("fixed one sync mode did not assert low output");

	property p_sync_fixed_zero;
		(c_sync[3:0] > 4'hA && c_sync[4]) |=> !sync_out;
	endproperty
	a_sync_fixed_zero: assert property (p_sync_fixed_zero)
		else $error("fixed zero sync mode asserted high output");

	property p_sync_all;
		(c_sync[4:0] == 5'h01) |=> (sync_out == !(&$past(sync_v)));
	endproperty
	a_sync_all: assert property (p_sync_all)
		else $error("all-lane sync combine wrong");

	property p_reinit_never;
		(c_sync[7:5] == 3'h7) |=> !reinit_request;
	endproperty
	a_reinit_never: assert property (p_reinit_never)
		else $error("reinit request raised while held off");

	property p_invert_lane0;
		(edge_v[0] && c_pol[0] && !c_ca[4]) |=>
			lane_out[0].data == ~$past(lane_in[0].align_input);
	endproperty
	a_invert_lane0: assert property (p_invert_lane0)
		else $error("lane 0 data not inverted");

	property p_reverse_lane0;
		(edge_v[0] && !c_pol[0] && c_ca[4]) |=>
			lane_out[0].data == slasc_reverse($past(lane_in[0].align_input));
	endproperty
	a_reverse_lane0: assert property (p_reverse_lane0)
		else $error("lane 0 data not bit reversed");

	property p_hold_off_edge;
		!edge_v[1] |=> $stable(lane_out[1].data) && !lane_out[1].data_valid;
	endproperty
	a_hold_off_edge: assert property (p_hold_off_edge)
		else $error("lane 1 sampled without its edge");

	property p_scr_manual;
		c_scr[2] |=> lane_out[2].descramble_on == $past(c_scr[6]);
	endproperty
	a_scr_manual: assert property (p_scr_manual)
		else $error("lane 2 descramble ignores manual bit");

	property p_lock_auto;
		(rst_n && !c_lock[7]) |=>
			lane_out[3].word_pos == $past(lane_in[3].auto_lock_pos);
	endproperty
	a_lock_auto: assert property (p_lock_auto)
		else $error("lane 3 word position not automatic");

	property p_ila_off;
		!c_ila[1] |=> ila_strobe == 2'b00;
	endproperty
	a_ila_off: assert property (p_ila_off)
		else $error("alignment strobe while disabled");

	property p_ila_reset;
		sr_write |=> ila_aligned == 2'b00 ##1 ila_strobe == 2'b00;
	endproperty
	a_ila_reset: assert property (p_ila_reset)
		else $error("soft reset left alignment standing");

	property p_err_and;
		(c_err[5:4] == 2'b01) |=> ctrl_err_trig[0] == &$past(unexp_v[1:0]);
	endproperty
	a_err_and: assert property (p_err_and)
		else $error("lower pair and-select wrong");
endmodule
`default_nettype wire

// ===== sim/slasc_tx_model.sv
// far-side lane transmitter model feeding the lane inputs
`timescale 1ns/1ps
`default_nettype none
module slasc_tx_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sync_out,
	input wire logic sync_request_polarity,
	input wire slasc_pkg::slasc_lane_in_t [3:0] lane_base,
	output slasc_pkg::slasc_lane_in_t [3:0] lane_in
);
	logic [7:0] cnt;
	logic [3:0] dclk;
	logic [3:0] a_sym;
	logic [3:0][7:0] byte_q;
	logic req;
	assign req = (sync_out === sync_request_polarity);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
			dclk <= 4'h0;
			a_sym <= 4'h0;
			byte_q <= '0;
		end else begin
			cnt <= cnt + 8'h01;
			for (int l = 0; l < 4; l++) begin
				if ((cnt + 8'(l)) % 8'h03 == 8'h00) dclk[l] <= ~dclk[l];
				byte_q[l] <= cnt * 8'h1D + 8'(l) * 8'h40;
				a_sym[l] <= !req && (cnt[1:0] == 2'h0);
			end
		end
	end
	always_comb begin
		lane_in = lane_base;
		for (int l = 0; l < 4; l++) begin
			lane_in[l].divided_clock = dclk[l];
			lane_in[l].align_input = byte_q[l];
			lane_in[l].a_symbol = a_sym[l];
		end
	end
endmodule
`default_nettype wire

// ===== sim/slasc_tb.sv
// self-checking bench for the lane align and sync control block
`timescale 1ns/1ps
`default_nettype none
module slasc_tb;
	localparam logic [15:0] ML = 16'h3E9C;
	localparam logic [15:0] MD = 16'h7F10;
	localparam logic [23:0] FAIL = 24'h7BDE07;
	localparam logic [23:0] PASS = 24'h84214F;
	logic ref_clk;
	logic rst_n;
	logic sync_request_polarity;
	logic chk_dp;
	slasc_pkg::slasc_reg_req_t reg_req;
	slasc_pkg::slasc_lane_in_t [3:0] lane_base;
	slasc_pkg::slasc_lane_in_t [3:0] lane_in;
	slasc_pkg::slasc_lane_in_t [3:0] lb;
	slasc_pkg::slasc_lane_in_t [3:0] s0;
	slasc_pkg::slasc_lane_in_t [3:0] s1;
	slasc_pkg::slasc_lane_out_t [3:0] lane_out;
	logic [7:0] reg_rdata;
	logic [7:0] d;
	logic [1:0] ila_aligned;
	logic [1:0] ila_strobe;
	logic [1:0] ctrl_err_trig;
	logic [1:0] code_err_trig;
	logic reinit_request;
	logic sync_out;
	logic [3:0] swp;
	logic [3:0] e_sel;
	logic [3:0] inv;
	int error_cnt;
	int n_compared;
	int n;
	// err sel, sync mode, sync/rst/ctrl/code lanes, sync pin, reinit, trigs
	logic [47:0] rows [0:28] = '{
		48'h0000_0000_1000, 48'h0000_4000_0000, 48'h0001_7000_1000,
		48'h0001_F000_0000, 48'h0002_C000_1000, 48'h0003_3000_0000,
		48'h0004_3000_1000, 48'h0005_4000_1000, 48'h0006_1000_0000,
		48'h0007_D000_1000, 48'h0008_4000_0000, 48'h0009_7000_1000,
		48'h001A_0000_1000, 48'h000B_F000_1000, 48'h001F_F000_0000,
		48'h0010_1000_1000, 48'h0000_0400_1100, 48'h0020_0C00_1000,
		48'h0040_0400_1100, 48'h0060_0E00_1000, 48'h0080_0200_1100,
		48'h00A0_0B00_1000, 48'h00C0_0800_1100, 48'h00E0_0F00_1000,
		48'h0000_0018_1012, 48'h5500_007C_1012, 48'hAA00_0061_1021,
		48'hFF00_0068_1012, 48'h000A_0000_0000};

	always #2 ref_clk = ~ref_clk;

	slasc_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
		.lane_in(lane_in), .reg_rdata(reg_rdata), .lane_out(lane_out),
		.ila_aligned(ila_aligned), .ila_strobe(ila_strobe),
		.ctrl_err_trig(ctrl_err_trig), .code_err_trig(code_err_trig),
		.reinit_request(reinit_request), .sync_out(sync_out));
	slasc_tx_model far (.ref_clk(ref_clk), .rst_n(rst_n),
		.sync_out(sync_out), .sync_request_polarity(sync_request_polarity), .lane_base(lane_base),
		.lane_in(lane_in));

	task results;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge ref_clk);
		reg_req <= '0;
	endtask
	task rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		reg_req <= '0;
		@(negedge ref_clk);
		v = reg_rdata;
	endtask
	// lock, sync, reset, ctrl err, code err, misaligned nibbles
	task lanes(input logic [23:0] v);
		@(posedge ref_clk);
		lb = lane_base;
		for (int l = 0; l < 4; l++) begin
			lb[l].locked = v[20 + l];
			lb[l].lane_sync = v[16 + l];
			lb[l].lane_reset = v[12 + l];
			lb[l].unexpected_ctrl = v[8 + l];
			lb[l].code_error = v[4 + l];
			lb[l].misaligned = v[l];
		end
		lane_base <= lb;
	endtask
	task wait_al(input logic [1:0] e);
		for (int i = 0; i < 100 && ila_aligned !== e; i++) @(negedge ref_clk);
		chk(8'(ila_aligned), 8'(e));
		if (ila_aligned !== e) results();
	endtask
	task wait_strobe(input logic [7:0] exp);
		int i;
		n = 0;
		@(negedge ref_clk);
		chk(8'(ila_aligned), 8'h00);
		for (i = 0; i < 200 && ila_strobe[0] !== 1'b1; i++) begin
			@(negedge ref_clk);
			if (ila_strobe[0] !== 1'b1) n += int'(lane_in[0].a_symbol);
		end
		chk(8'(n), exp);
		chk(8'(ila_aligned), 8'h03);
		chk(8'(ila_strobe), 8'h03);
		if (i == 200) results();
	endtask
	task dp_run(input logic [7:0] ca, input logic [7:0] pol);
		wr(5'h05, ca);
		wr(5'h0D, pol);
		@(posedge ref_clk);
		swp = ca[7:4];
		e_sel = ca[3:0];
		inv = pol[3:0];
		chk_dp = 1'b1;
		repeat (40) @(posedge ref_clk);
		chk_dp = 1'b0;
	endtask
	function automatic logic [7:0] xf(input logic [7:0] b, input logic s,
		input logic v);
		logic [7:0] r;
		r = v ? ~b : b;
		return s ? {<<{r}} : r;
	endfunction

	always @(negedge ref_clk) begin
		for (int l = 0; l < 4; l++) begin
			if (chk_dp) begin
				chk(8'(lane_out[l].data_valid), 8'(s1[l].divided_clock !=
					s0[l].divided_clock && s1[l].divided_clock == e_sel[l]));
				if (lane_out[l].data_valid === 1'b1)
					chk(lane_out[l].data, xf(s1[l].align_input, swp[l], inv[l]));
			end
		end
		s0 = s1;
		s1 = lane_in;
	end

	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		sync_request_polarity = 1'b0;
		chk_dp = 1'b0;
		reg_req = '0;
		lane_base = '0;
		error_cnt = 0;
		n_compared = 0;
		for (int l = 0; l < 4; l++) begin
			lane_base[l].auto_lock_pos = 4'(l + 1);
			lane_base[l].auto_delay = 4'h5;
		end
		repeat (10) @(posedge ref_clk);
		chk(8'(sync_out), 8'h01);
		rst_n <= 1'b1;
		for (int a = 1; a < 15; a++) begin
			rd(5'(a), d);
			chk(d, a == 7 ? 8'h83 : 8'h00);
		end
		for (int a = 2; a < 15; a++) begin
			wr(5'(a), 8'h5A ^ 8'(a));
			rd(5'(a), d);
			chk(d, a == 14 ? 8'h00 : 8'h5A ^ 8'(a));
			wr(5'(a), a == 7 ? 8'h83 : 8'h00);
		end
		for (int i = 0; i < 29; i++) begin
			sync_request_polarity <= rows[i][36];
			wr(5'h0B, rows[i][47:40]);
			wr(5'h0C, rows[i][39:32]);
			lanes({4'h0, rows[i][31:16], 4'h0});
			repeat (3) @(negedge ref_clk);
			chk(8'(sync_out), 8'(rows[i][12]));
			chk(8'(reinit_request), 8'(rows[i][8]));
			chk(8'(ctrl_err_trig), 8'(rows[i][5:4]));
			chk(8'(code_err_trig), 8'(rows[i][1:0]));
		end
		wr(5'h0B, 8'h00);
		wr(5'h0C, 8'h00);
		sync_request_polarity <= 1'b0;
		lanes(24'h500000);
		wr(5'h03, 8'h9C);
		wr(5'h04, 8'h3E);
		wr(5'h02, 8'h50);
		wr(5'h09, 8'h10);
		wr(5'h0A, 8'h7F);
		wr(5'h08, 8'h01);
		wr(5'h06, 8'hA3);
		repeat (3) @(negedge ref_clk);
		for (int l = 0; l < 4; l++) begin
			chk(8'(lane_out[l].word_pos), 8'(l[0] ? 4'(l + 1) : ML[4*l+:4]));
			chk(8'(lane_out[l].align_delay), 8'(MD[4*l+:4]));
			chk(8'(lane_out[l].descramble_on), 8'(l == 1 || l == 2));
		end
		wr(5'h08, 8'h00);
		wr(5'h07, 8'h82);
		wr(5'h02, 8'h00);
		repeat (3) @(negedge ref_clk);
		for (int l = 0; l < 4; l++) begin
			chk(8'(lane_out[l].word_pos), 8'(l + 1));
			chk(8'(lane_out[l].align_delay), 8'h05);
			chk(8'(lane_out[l].descramble_on), 8'(l == 1));
		end
		dp_run(8'h5A, 8'h06);
		dp_run(8'hA5, 8'h09);
		lanes(24'hF00000);
		for (int c = 0; c < 4; c++) begin
			wr(5'h07, 8'h83 | 8'(c) << 5);
			wr(5'h02, 8'h01);
			wait_strobe(8'(c + 1));
		end
		wr(5'h02, 8'h00);
		repeat (3) @(negedge ref_clk);
		chk(8'(ila_aligned), 8'h03);
		for (int s = 0; s < 6; s++) begin
			lanes({FAIL[4*s+:4], 20'h0});
			wr(5'h07, 8'h83 | 8'(s) << 2);
			wr(5'h02, 8'h01);
			repeat (30) @(negedge ref_clk);
			chk(8'(ila_aligned), 8'h00);
			lanes({PASS[4*s+:4], 20'h0});
			wait_al(2'h3);
		end
		wr(5'h07, 8'h03);
		lanes(24'h300000);
		wr(5'h02, 8'h01);
		wait_al(2'h1);
		repeat (20) @(negedge ref_clk);
		chk(8'(ila_aligned), 8'h01);
		wr(5'h07, 8'h83);
		wr(5'h02, 8'h01);
		repeat (30) @(negedge ref_clk);
		chk(8'(ila_aligned), 8'h00);
		lanes(24'hF00000);
		wr(5'h07, 8'h81);
		wr(5'h02, 8'h01);
		repeat (30) @(negedge ref_clk);
		chk(8'(ila_aligned), 8'h00);
		wr(5'h07, 8'h83);
		wr(5'h02, 8'h01);
		wait_al(2'h3);
		lanes(24'hF00001);
		repeat (10) @(negedge ref_clk);
		chk(8'(ila_aligned), 8'h03);
		wr(5'h08, 8'h02);
		wait_al(2'h0);
		lanes(24'hF00000);
		wait_al(2'h3);
		results();
	end
endmodule
`default_nettype wire
